/* File: logic/uvp_defines.vh */
/*
 * constants for the eprom programming sequencer: pulse times, supply
 * sequencing and bus timing, all counted in cycles of a 250 MHz clock.
 * assumes the including file works in plain verilog-2005.
 */
`ifndef UVP_DEFINES_VH
`define UVP_DEFINES_VH

// clock rate in MHz, so ns times divide by 4 and us times multiply by 250
`define UVP_CLK_MHZ        250
// initial program pulse, us, centre of the 0.95..1.05 ms window
`define UVP_PULSE_US       1000
`define UVP_PULSE_CYC      (`UVP_PULSE_US * `UVP_CLK_MHZ)
// overprogram pulse is this many times the count of initial pulses
`define UVP_OVER_MULT      3
// most initial pulses per byte
`define UVP_MAX_PULSES     25
// setup and hold times, us
`define UVP_SETUP_US       2
`define UVP_SETUP_CYC      (`UVP_SETUP_US * `UVP_CLK_MHZ)
// supply settle time before a step may follow, us
`define UVP_SUPPLY_US      2
`define UVP_SUPPLY_CYC     (`UVP_SUPPLY_US * `UVP_CLK_MHZ)
// output valid after gate low, ns, rounded up to whole cycles
`define UVP_OE_NS          150
`define UVP_OE_CYC         ((`UVP_OE_NS + 3) / 4)
// address to data for a read, ns
`define UVP_ACC_NS         250
`define UVP_ACC_CYC        ((`UVP_ACC_NS + 3) / 4)
// data float after gate high, ns
`define UVP_DF_NS          130
`define UVP_DF_CYC         ((`UVP_DF_NS + 3) / 4)

`endif

/* File: logic/uvp_timer.v */
/*
 * down counter used by the sequencer for every timed step.
 * assumes one clock and synchronous active high reset.
 */
module uvp_timer #(
  parameter W = 24
) (
  // clock and reset
  input  wire         clk,
  input  wire         srst,
  // load and status
  input  wire         load,
  input  wire [W-1:0] count,
  output wire         done
);

  reg [W-1:0] cnt_q;

  // reload on request, else count to zero and hold
  always @(posedge clk) begin
    if (srst) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done = (cnt_q == {W{1'b0}}) & ~load;

endmodule // uvp_timer

/* File: logic/uvp_programmer.v */
/*
 * programmer side of a byte-wide uv eprom: runs the fast programming
 * loop over a range of bytes, the final read back, single reads and the
 * identification readout. source bytes come from the user per address.
 * assumes level shifters on the supply controls and a 250 MHz clock.
 */
`include "uvp_defines.vh"

// What this block does
// - set address, data, raise core supply first
// - one ms pulse, then verify the byte
// - pass after first pulse gives 3 ms overprogram
// - retry one ms pulses, up to twenty-five
// - overprogram is three times pulses used
// - fail after twenty-five pulses, then stop
// - advance address, repeat until range done
// - lower supply, read back all, compare
// - initial pulse within one ms five percent
// - overprogram between 2.85 and 78.75 ms
// - core supply on first, off last
// - programming supply raised only while programming
// - raise id pin to high voltage for id
// - other address inputs low during id read
module uvp_programmer #(
  parameter AW = 14,
  parameter TW = 25,
  parameter PW = `UVP_PULSE_CYC
) (
  // clock and reset
  input  wire          clk,
  input  wire          srst,
  // user commands, one-cycle pulses, taken only when idle
  input  wire          start_prog,
  input  wire          start_read,
  input  wire          start_id,
  input  wire [AW-1:0] first_addr,
  input  wire [AW-1:0] last_addr,
  // source data lookup for src_addr
  output reg  [AW-1:0] src_addr,
  input  wire [7:0]    src_data,
  // results
  output reg           busy,
  output reg           done,
  output reg           pass,
  output reg  [7:0]    read_data,
  output reg  [4:0]    pulses_used,
  // device pins
  output reg  [AW-1:0] address_inputs,
  output reg           id_high_voltage_pin,
  output reg           chip_select_n,
  output reg           output_gate_n,
  output reg           program_strobe_low,
  output reg  [7:0]    data_out,
  output reg           data_oe,
  input  wire [7:0]    data_outputs,
  output reg           vcc_high,
  output reg           vpp_high
);

  localparam S_IDLE  = 4'd0;
  localparam S_VCCUP = 4'd1;
  localparam S_VPPUP = 4'd2;
  localparam S_SETUP = 4'd3;
  localparam S_PULSE = 4'd4;
  localparam S_HOLD  = 4'd5;
  localparam S_VFY   = 4'd6;
  localparam S_OVER  = 4'd7;
  localparam S_VPPDN = 4'd8;
  localparam S_VCCDN = 4'd9;
  localparam S_RBACK = 4'd10;
  localparam S_READ  = 4'd11;
  localparam S_FLOAT = 4'd12;
  localparam S_FIN   = 4'd13;

  localparam [TW-1:0] T_PULSE  = PW;
  localparam [TW-1:0] T_OVER   = `UVP_OVER_MULT * PW;
  localparam [TW-1:0] T_SETUP  = `UVP_SETUP_CYC;
  localparam [TW-1:0] T_SUPPLY = `UVP_SUPPLY_CYC;
  localparam [TW-1:0] T_OE     = `UVP_OE_CYC;
  localparam [TW-1:0] T_ACC    = `UVP_ACC_CYC;
  localparam [TW-1:0] T_DF     = `UVP_DF_CYC;
  localparam [4:0]    MAXP     = `UVP_MAX_PULSES;
  localparam [1:0]    K_PROG   = 2'd0;
  localparam [1:0]    K_READ   = 2'd1;
  localparam [1:0]    K_ID     = 2'd2;

  reg  [3:0]    st_q;
  reg  [3:0]    st_prev_q;
  reg  [1:0]    kind_q;
  reg  [4:0]    cnt_q;     // pulses given to this byte
  reg  [4:0]    over_q;    // initial pulses used, in units of the 3 ms overprogram step
  reg           rb_q;      // final read back phase
  reg  [AW-1:0] last_q;
  reg  [7:0]    sy1_q;
  reg  [7:0]    sy2_q;
  reg           t_load;
  reg  [TW-1:0] t_count;
  wire          t_done;
  wire          last_byte;

  uvp_timer #(
    .W (TW)
  ) u_timer (
    .clk   (clk),
    .srst  (srst),
    .load  (t_load),
    .count (t_count),
    .done  (t_done)
  );

  assign last_byte = (address_inputs == last_q);

  // two-stage synchroniser for the device data pins
  always @(posedge clk) begin
    if (srst) begin
      sy1_q <= 8'h00;
      sy2_q <= 8'h00;
    end else begin
      sy1_q <= data_outputs;
      sy2_q <= sy1_q;
    end
  end

  // timer loads on the first cycle of every state, with that state's time
  always @* begin
    t_load  = (st_q != st_prev_q);
    case (st_q)
      S_VCCUP, S_VPPUP, S_VPPDN, S_VCCDN: t_count = T_SUPPLY;
      S_PULSE:          t_count = T_PULSE;
      S_VFY:            t_count = T_OE;
      // overprogram time scales with pulses used
      S_OVER:           t_count = {{(TW-5){1'b0}}, over_q} * T_OVER;
      S_READ, S_FLOAT:  t_count = T_ACC;
      S_FIN:            t_count = T_DF;
      default:          t_count = T_SETUP;
    endcase
  end

  // main sequencer
  always @(posedge clk) begin
    if (srst) begin
      st_q                <= S_IDLE;
      kind_q              <= K_PROG;
      cnt_q               <= 5'h00;
      over_q              <= 5'h00;
      rb_q                <= 1'b0;
      last_q              <= {AW{1'b0}};
      src_addr            <= {AW{1'b0}};
      busy                <= 1'b0;
      done                <= 1'b0;
      pass                <= 1'b0;
      read_data           <= 8'h00;
      pulses_used         <= 5'h00;
      address_inputs      <= {AW{1'b0}};
      id_high_voltage_pin <= 1'b0;
      chip_select_n       <= 1'b1;
      output_gate_n       <= 1'b1;
      program_strobe_low  <= 1'b1;
      data_out            <= 8'h00;
      data_oe             <= 1'b0;
      vcc_high            <= 1'b0;
      vpp_high            <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (start_prog) begin
            kind_q         <= K_PROG;
            vcc_high       <= 1'b1;
            address_inputs <= first_addr;
            src_addr       <= first_addr;
            last_q         <= last_addr;
            rb_q           <= 1'b0;
            pass           <= 1'b1;
            busy           <= 1'b1;
            st_q           <= S_VCCUP;
          end else if (start_read || start_id) begin
            // read with select and gate low
            kind_q         <= start_id ? K_ID : K_READ;
            busy           <= 1'b1;
            chip_select_n  <= 1'b0;
            output_gate_n  <= 1'b0;
            // id pin lifted to high voltage
            id_high_voltage_pin <= start_id;
            // only id byte select may be high
            address_inputs <= start_id ? {{(AW-1){1'b0}}, first_addr[0]} : first_addr;
            st_q           <= S_READ;
          end
        end
        S_VCCUP: begin
          if (t_done) begin
            vpp_high <= 1'b1;
            st_q     <= S_VPPUP;
          end
        end
        S_VPPUP: begin
          if (t_done) begin
            cnt_q         <= 5'h00;
            chip_select_n <= 1'b0;
            data_out      <= src_data;
            data_oe       <= 1'b1;
            st_q          <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (t_done) begin
            program_strobe_low <= 1'b0;
            st_q               <= S_PULSE;
          end
        end
        S_PULSE: begin
          // pulse length from the one ms count
          if (t_done) begin
            program_strobe_low <= 1'b1;
            st_q               <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (t_done) begin
            data_oe <= 1'b0;
            if (over_q != 5'h00) begin
              // overprogram done, move on
              over_q <= 5'h00;
              st_q   <= S_FLOAT;
            end else begin
              output_gate_n <= 1'b0;
              if (cnt_q != MAXP) begin
                cnt_q <= cnt_q + 5'h01;
              end
              st_q <= S_VFY;
            end
          end
        end
        S_VFY: begin
          if (t_done) begin
            output_gate_n <= 1'b1;
            if (sy2_q == src_data) begin
              over_q      <= cnt_q;
              pulses_used <= cnt_q;
              data_oe     <= 1'b1;
              st_q        <= S_OVER;
            end else if (cnt_q == MAXP) begin
              pass        <= 1'b0;
              pulses_used <= cnt_q;
              st_q        <= S_VPPDN;
            end else begin
              data_oe <= 1'b1;
              st_q    <= S_SETUP;
            end
          end
        end
        S_OVER: begin
          if (t_done) begin
            program_strobe_low <= 1'b1;
            st_q               <= S_HOLD;
          end else begin
            program_strobe_low <= 1'b0;
          end
        end
        S_FLOAT: begin
          if (t_done) begin
            if (rb_q) begin
              if (sy2_q != src_data) begin
                pass <= 1'b0;
              end
            end
            if (last_byte) begin
              chip_select_n <= 1'b1;
              output_gate_n <= 1'b1;
              st_q          <= rb_q ? S_FIN : S_VPPDN;
            end else begin
              address_inputs <= address_inputs + {{(AW-1){1'b0}}, 1'b1};
              src_addr       <= address_inputs + {{(AW-1){1'b0}}, 1'b1};
              cnt_q          <= 5'h00;
              // source byte for the new address is ready one cycle later
              st_q           <= S_RBACK;
            end
          end
        end
        S_VPPDN: begin
          chip_select_n <= 1'b1;
          vpp_high      <= 1'b0;
          if (t_done) begin
            st_q <= S_VCCDN;
          end
        end
        S_VCCDN: begin
          if (t_done) begin
            vcc_high <= 1'b0;
            if (pass) begin
              // normal supply then read back all
              rb_q           <= 1'b1;
              address_inputs <= first_addr;
              src_addr       <= first_addr;
              chip_select_n  <= 1'b0;
              output_gate_n  <= 1'b0;
              st_q           <= S_RBACK;
            end else begin
              st_q <= S_FIN;
            end
          end
        end
        S_RBACK: begin
          if (rb_q) begin
            st_q <= S_FLOAT;
          end else begin
            data_out <= src_data;
            data_oe  <= 1'b1;
            st_q     <= S_SETUP;
          end
        end
        S_READ: begin
          if (t_done) begin
            // id byte select picks the code
            read_data      <= sy2_q;
            chip_select_n  <= 1'b1;
            output_gate_n  <= 1'b1;
            st_q           <= S_FIN;
          end
        end
        S_FIN: begin
          if (t_done) begin
            id_high_voltage_pin <= 1'b0;
            busy                <= 1'b0;
            done                <= 1'b1;
            st_q                <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // previous state, so the timer can spot the entry into a state
  always @(posedge clk) begin
    if (srst) begin
      st_prev_q <= S_IDLE;
    end else begin
      st_prev_q <= st_q;
    end
  end

endmodule // uvp_programmer

/* File: verification/uvp_programmer_properties.sv */
/* checker for uvp_programmer: supply order, strobe widths, id pins.
   assumes a 250 MHz clk and a bind onto the design top. */
module uvp_programmer_chk #(
  parameter AW = 14,
  parameter int PW = 250000
) (
  // clock and reset
  input wire logic          clk,
  input wire logic          srst,
  // status
  input wire logic          busy,
  input wire logic          done,
  // device pins
  input wire logic [AW-1:0] address_inputs,
  input wire logic          id_high_voltage_pin,
  input wire logic          chip_select_n,
  input wire logic          output_gate_n,
  input wire logic          program_strobe_low,
  input wire logic [7:0]    data_out,
  input wire logic          data_oe,
  input wire logic          vcc_high,
  input wire logic          vpp_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // pulse limits in 4 ns cycles, overprogram limits per initial pulse
  localparam int PW_MIN  = PW * 95 / 100;
  localparam int PW_MAX  = PW * 105 / 100;
  localparam int OPW_MIN = 3 * PW_MIN;
  localparam int OPW_MAX = 3 * PW_MAX;
  logic [24:0] w_q;
  logic [4:0]  n_q;
  logic        s_q;
  wire         rise = program_strobe_low & ~s_q;
  // strobe low width and initial pulses since the last overprogram
  always @(posedge clk) begin
    if (srst) begin
      w_q <= '0;
      n_q <= '0;
      s_q <= 1'b1;
    end else begin
      s_q <= program_strobe_low;
      w_q <= program_strobe_low ? 25'h0 : w_q + 25'h1;
      if (!busy)
        n_q <= '0;
      else if (rise)
        n_q <= (w_q <= PW_MAX) ? n_q + 5'h1 : 5'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ****************
  // assertions
  // ****************
  a_vcc_before_vpp: assert property (vpp_high |-> vcc_high)
    else $error("programming supply up without core supply");
  a_pulse_setup: assert property (!program_strobe_low |-> vpp_high && !chip_select_n
      && output_gate_n && data_oe && !id_high_voltage_pin)
    else $error("strobe low outside program setup");
  a_data_held: assert property (!program_strobe_low && !s_q
      |-> $stable(address_inputs) && $stable(data_out))
    else $error("address or data moved during strobe");
  a_no_contention: assert property (data_oe |-> output_gate_n)
    else $error("data driven while output gate low");
  a_init_width: assert property (rise && w_q <= PW_MAX |-> w_q >= PW_MIN)
    else $error("initial pulse too short");
  a_over_scaled: assert property (rise && w_q > PW_MAX |-> n_q >= 5'h1
      && w_q >= n_q * OPW_MIN && w_q <= n_q * OPW_MAX)
    else $error("overprogram width not scaled to pulse count");
  a_pulse_limit: assert property (n_q <= 5'd25)
    else $error("more than 25 initial pulses");
  a_id_quiet: assert property (id_high_voltage_pin && !output_gate_n
      |-> !vpp_high && address_inputs[AW-1:1] == '0)
    else $error("id read with other address bits or vpp high");
  a_done_idle: assert property (done |-> !busy && !vcc_high && !vpp_high)
    else $error("done with busy or supplies raised");
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
endmodule // uvp_programmer_chk

bind uvp_programmer uvp_programmer_chk #(.AW(AW), .PW(PW)) uvp_programmer_chk_i (
  .clk, .srst, .busy, .done, .address_inputs, .id_high_voltage_pin, .chip_select_n,
  .output_gate_n, .program_strobe_low, .data_out, .data_oe, .vcc_high, .vpp_high);

/* File: verification/uvp_eprom_model.sv */
/* behavioural model of the byte-wide uv eprom on the pins.
   assumes the bench merges data_q with the programmer's own drive. */
module uvp_eprom_model #(
  parameter       AW         = 14,
  parameter [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter [7:0] PART_CODE  = 8'ha6  // arbitrary value
) (
  // control pins
  input wire logic [AW-1:0] address_inputs,
  input wire logic          id_high_voltage_pin,
  input wire logic          chip_select_n,
  input wire logic          output_gate_n,
  input wire logic          program_strobe_low,
  input wire logic          vcc_high,
  input wire logic          vpp_high,
  // data bus
  input wire logic [7:0]    data_in,
  output wire logic [7:0]   data_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem   [0:(1<<AW)-1];
  int         needs [0:(1<<AW)-1];
  int         hits  [0:(1<<AW)-1];
  logic [7:0] val;
  logic [7:0] last_q = 8'h00;
  wire        drive = !chip_select_n && !output_gate_n && program_strobe_low;
  // erased array, one pulse per byte unless the bench asks for more
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = 8'hff;
      needs[i] = 1;
      hits[i] = 0;
    end
  end
  always @* begin
    if (id_high_voltage_pin)
      val = address_inputs[0] ? PART_CODE : MAKER_CODE;
    else
      val = mem[address_inputs];
  end
  // released bus shows inverse of last byte
  always @* begin
    if (drive)
      last_q = val;
  end
  assign data_q = drive ? val : ~last_q;
  always @(posedge program_strobe_low) begin
    if (!chip_select_n && output_gate_n && vpp_high && vcc_high) begin
      hits[address_inputs] += 1;
      if (hits[address_inputs] >= needs[address_inputs])
        mem[address_inputs] &= data_in;
    end
  end
endmodule // uvp_eprom_model

/* File: verification/uvp_programmer_tb.sv */
/* self-checking bench for uvp_programmer with an eprom model.
   assumes the checker is bound in by its own file. */
module uvp_programmer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         AW    = 14;
  localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
  localparam logic [7:0] PART  = 8'ha6; // arbitrary value
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  logic          start_prog = 1'b0;
  logic          start_read = 1'b0;
  logic          start_id = 1'b0;
  logic [AW-1:0] first_addr = '0;
  logic [AW-1:0] last_addr = '0;
  logic [AW-1:0] a;
  logic [7:0]    v;
  logic [7:0]    rnd = 8'd59;
  int            err_total = 0;
  int            checks_done = 0;
  wire [AW-1:0]  src_addr, address_inputs;
  wire [7:0]     src_data, read_data, data_out, data_outputs, bus_q;
  wire [4:0]     pulses_used;
  wire           busy, done, pass, id_high_voltage_pin, chip_select_n, output_gate_n;
  wire           program_strobe_low, data_oe, vcc_high, vpp_high;
  // ****************
  // design, model and bus merge
  // ****************
  uvp_programmer #(.AW(AW), .PW(400)) uvp_programmer_i (
    .clk, .srst, .start_prog, .start_read, .start_id, .first_addr, .last_addr, .src_addr,
    .src_data, .busy, .done, .pass, .read_data, .pulses_used, .address_inputs,
    .id_high_voltage_pin, .chip_select_n, .output_gate_n, .program_strobe_low, .data_out,
    .data_oe, .data_outputs, .vcc_high, .vpp_high);
  uvp_eprom_model #(.AW(AW), .MAKER_CODE(MAKER), .PART_CODE(PART)) uvp_eprom_model_i (
    .address_inputs, .id_high_voltage_pin, .chip_select_n, .output_gate_n,
    .program_strobe_low, .vcc_high, .vpp_high, .data_in(data_out), .data_q(bus_q));
  assign data_outputs = data_oe ? data_out : bus_q;
  assign src_data = src_fn(src_addr);
  function automatic logic [7:0] src_fn(input logic [AW-1:0] x);
    return x[7:0] ^ 8'h3c;
  endfunction
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // compare one byte and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // launch one command and wait for done
  task automatic cmd(input int kind, input logic [AW-1:0] f, input logic [AW-1:0] l);
    int n;
    @(posedge clk);
    #1;
    first_addr = f;
    last_addr = l;
    start_prog = (kind == 0);
    start_read = (kind == 1);
    start_id = (kind == 2);
    @(posedge clk);
    #1;
    {start_prog, start_read, start_id} = 3'b000;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (done !== 1'b1) begin
      err_total++;
      $display("ERROR %0t: no done", $time);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    forever #2 clk = ~clk;
  end
  // watchdog past the longest programming run
  initial begin
    #200000;
    err_total++;
    $display("ERROR %0t: watchdog", $time);
    results();
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (20) @(posedge clk);
    #1;
    srst = 1'b0;
    // id codes, random upper address bits
    for (int b = 0; b < 2; b++) begin
      rnd = lfsr(rnd);
      cmd(2, {6'h00, rnd[6:0], b[0]}, '0);
      chk(read_data, b[0] ? PART : MAKER);
    end
    // reads at both ends of the array and at random places
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      a = (i == 0) ? '0 : (i == 1) ? '1 : {rnd[5:0], rnd};
      v = lfsr(rnd) ^ 8'h81;
      uvp_eprom_model_i.mem[a] = v;
      cmd(1, a, a);
      chk(read_data, v);
    end
    // two bytes, the second needs two initial pulses
    rnd = lfsr(rnd);
    a = {6'h00, rnd};
    uvp_eprom_model_i.needs[a + 14'h1] = 2;
    cmd(0, a, a + 14'h1);
    chk({7'h00, pass}, 8'h01);
    chk({3'h0, pulses_used}, 8'h02);
    chk(uvp_eprom_model_i.mem[a], src_fn(a));
    chk(uvp_eprom_model_i.mem[a + 14'h1], src_fn(a + 14'h1));
    cmd(1, a + 14'h1, a + 14'h1);
    chk(read_data, src_fn(a + 14'h1));
    results();
  end
endmodule // uvp_programmer_tb
